/* include/scwa_pkg.sv */
// Constants for the system control word assembler.
// Assumes one 40 MHz clock and a symbol strobe from the OFDM timing.
`default_nettype none
package scwa_pkg;
    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int          WORD_W        = 32;
    localparam logic [6:0]  SYNC_HI       = 7'h32;
    localparam logic        SYNC_B22      = 1'b1;
    localparam logic        SYNC_B17      = 1'b0;
    localparam logic [1:0]  SYNC_LO       = 2'h3;
    localparam logic        RSV_B21       = 1'b0;
    localparam logic        RSV_B15       = 1'b0;
    localparam logic [2:0]  RSV_B8_6      = 3'h0;
    localparam int          POS_SYNC_HI   = 25;
    localparam int          POS_PWR       = 24;
    localparam int          POS_PAR3      = 23;
    localparam int          POS_HPID      = 20;
    localparam int          POS_AUD       = 19;
    localparam int          POS_PAR2      = 18;
    localparam int          POS_RBW       = 16;
    localparam int          POS_BLK       = 12;
    localparam int          POS_PAR1      = 11;
    localparam int          POS_SMODE     = 1;
    localparam int          POS_PAR0      = 0;
    // ------------------------------------------------------------------
    // Service modes and timing
    // ------------------------------------------------------------------
    localparam logic [4:0]  SMODE_NONE    = 5'h00;
    localparam logic [4:0]  SMODE_HYBRID  = 5'h01;
    localparam logic [4:0]  SMODE_ALL_DIG = 5'h02;
    localparam logic [4:0]  SYMS_PER_BLK  = 5'h1f;
    localparam logic [2:0]  BLK_RST       = 3'h0;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          FIFO_AW       = 4;
endpackage : scwa_pkg
`default_nettype wire

/* rtl/scwa_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module scwa_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wr_ff <= wr_ff + 1'b1;
            if (pop)  rd_ff <= rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : scwa_fifo
`default_nettype wire

/* rtl/scwa_serializer.sv */
// Shifts a 32-bit word out most significant bit first.
// Assumes the sink takes a bit whenever bit_valid and bit_ready meet.
`timescale 1ns/1ps
`default_nettype none
module scwa_serializer (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [31:0] word_data,
    input  wire logic        word_valid,
    output logic             word_ready,
    output logic             bit_data_ff,
    output logic             bit_valid_ff,
    input  wire logic        bit_ready
);
    logic [31:0] sh_ff;
    logic [5:0]  left_ff;
    logic        take;

    // Reload only on the edge that takes the last bit from the output stage, or once it has left
    assign word_ready = (left_ff == 6'h00) && !(bit_valid_ff && !bit_ready);
    assign take       = word_valid && word_ready;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sh_ff        <= '0;
            left_ff      <= '0;
            bit_data_ff  <= 1'b0;
            bit_valid_ff <= 1'b0;
        end else if (take) begin
            bit_data_ff  <= word_data[31];
            bit_valid_ff <= 1'b1;
            sh_ff        <= {word_data[30:0], 1'b0};
            left_ff      <= 6'h1f;
        end else if (!bit_valid_ff || bit_ready) begin
            bit_valid_ff <= (left_ff != 6'h00);
            bit_data_ff  <= sh_ff[31];
            sh_ff        <= {sh_ff[30:0], 1'b0};
            if (left_ff != 6'h00) left_ff <= left_ff - 6'h01;
        end
    end
endmodule : scwa_serializer
`default_nettype wire

/* rtl/scwa_assembler.sv */
// System control word assembler: builds one 32-bit word per block.
// Assumes sym_strobe pulses once per OFDM symbol and a mapper that
// takes bits on a valid/ready pair.
//
// Functional notes
// - Fixed sync bits in every word
// - Bit 24 is the power level flag
// - Parity bits 23 and 18 are even
// - Parity bits 11 and 0 are even
// - Bit 19 is the audio bandwidth flag
// - Bit 20 ids flag, bit 16 reduced bandwidth
// - Block counter modulo eight, every 32 symbols
// - Bits 5:1 carry the service mode code
// - All-digital mode forces power flag low
// - Reduced bandwidth forces power flag low
// - Otherwise power flag follows control setting
// - Reduced bandwidth forces ids flag low
// - Service mode code values none, hybrid, all-digital
// - Word leaves most significant bit first
// - First block counter after start is zero
`timescale 1ns/1ps
`default_nettype none
module scwa_assembler (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       tx_enable,
    input  wire logic       sym_strobe,
    input  wire logic       power_level_control,
    input  wire logic       high_power_control,
    input  wire logic       audio_bandwidth_ctl,
    input  wire logic       reduced_bandwidth_ctl,
    input  wire logic [4:0] service_mode_code,
    output logic            bit_data_ff,
    output logic            bit_valid_ff,
    input  wire logic       bit_ready,
    output logic [2:0]      block_counter_ff,
    output logic            block_strobe_ff,
    output logic            word_dropped_ff
);
    // ------------------------------------------------------------------
    // Word build
    // ------------------------------------------------------------------
    function automatic logic even_par(input logic [7:0] v);
        return ^v;
    endfunction : even_par

    typedef enum logic [1:0] {
        SCWA_IDLE = 2'b00,
        SCWA_RUN  = 2'b01
    } scwa_state_t;

    scwa_state_t  state_ff;
    logic [4:0]   sym_cnt_ff;
    logic [2:0]   nxt_blk;
    logic         boundary;
    logic         pwr_flag;
    logic         hpid_flag;
    logic [31:0]  word;
    logic         fifo_in_ready;
    logic [31:0]  fifo_out_data;
    logic         fifo_out_valid;
    logic         ser_ready;
    logic         push_ff;
    logic [31:0]  word_ff;

    // First boundary is the strobe that starts transmission
    assign boundary = sym_strobe && tx_enable &&
        ((state_ff == SCWA_IDLE) || (sym_cnt_ff == scwa_pkg::SYMS_PER_BLK));

    always_comb begin
        if (reduced_bandwidth_ctl) begin
            pwr_flag = 1'b0;
        end else if (service_mode_code == scwa_pkg::SMODE_ALL_DIG) begin
            pwr_flag = 1'b0;
        end else begin
            pwr_flag = power_level_control;
        end
        if (reduced_bandwidth_ctl) begin
            hpid_flag = 1'b0;
        end else begin
            hpid_flag = high_power_control;
        end
    end

    always_comb begin
        word = '0;
        word[31:25] = scwa_pkg::SYNC_HI;
        word[22]    = scwa_pkg::SYNC_B22;
        word[17]    = scwa_pkg::SYNC_B17;
        word[10:9]  = scwa_pkg::SYNC_LO;
        word[21]    = scwa_pkg::RSV_B21;
        word[15]    = scwa_pkg::RSV_B15;
        word[8:6]   = scwa_pkg::RSV_B8_6;
        word[scwa_pkg::POS_PWR]  = pwr_flag;
        word[scwa_pkg::POS_HPID] = hpid_flag;
        word[scwa_pkg::POS_AUD]  = audio_bandwidth_ctl;
        word[scwa_pkg::POS_RBW]  = reduced_bandwidth_ctl;
        word[14:12] = nxt_blk;
        word[5:1]   = service_mode_code;
        word[scwa_pkg::POS_PAR3] = even_par({7'h00, pwr_flag});
        word[scwa_pkg::POS_PAR2] =
            even_par({5'h00, scwa_pkg::RSV_B21, hpid_flag,
                      audio_bandwidth_ctl});
        word[scwa_pkg::POS_PAR1] =
            even_par({3'h0, reduced_bandwidth_ctl, scwa_pkg::RSV_B15,
                      nxt_blk});
        word[scwa_pkg::POS_PAR0] =
            even_par({scwa_pkg::RSV_B8_6, service_mode_code});
    end

    // Counter value for the word being built at this boundary
    assign nxt_blk = (state_ff == SCWA_IDLE) ? scwa_pkg::BLK_RST
                                             : block_counter_ff + 3'h1;

    // ------------------------------------------------------------------
    // Block timing
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= SCWA_IDLE;
        end else begin
            case (state_ff)
                SCWA_IDLE: if (boundary) state_ff <= SCWA_RUN;
                SCWA_RUN:  if (!tx_enable) state_ff <= SCWA_IDLE;
                default:   state_ff <= SCWA_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sym_cnt_ff <= '0;
        end else if (!tx_enable) begin
            sym_cnt_ff <= '0;
        end else if (boundary) begin
            sym_cnt_ff <= '0;
        end else if (sym_strobe) begin
            sym_cnt_ff <= sym_cnt_ff + 5'h01;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            block_counter_ff <= scwa_pkg::BLK_RST;
        end else if (boundary) begin
            block_counter_ff <= nxt_blk;
        end
    end

    // Word is latched at the boundary so later control changes wait
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            push_ff         <= 1'b0;
            word_ff         <= '0;
            block_strobe_ff <= 1'b0;
        end else begin
            push_ff         <= boundary;
            block_strobe_ff <= boundary;
            if (boundary) word_ff <= word;
        end
    end

    // A full FIFO means the mapper fell behind; the word is lost
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            word_dropped_ff <= 1'b0;
        end else begin
            word_dropped_ff <= push_ff && !fifo_in_ready;
        end
    end

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    scwa_fifo #(
        .WIDTH (scwa_pkg::WORD_W),
        .DEPTH (scwa_pkg::FIFO_DEPTH),
        .AW    (scwa_pkg::FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_data   (word_ff),
        .in_valid  (push_ff),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (ser_ready)
    );

    scwa_serializer u_ser (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .word_data    (fifo_out_data),
        .word_valid   (fifo_out_valid),
        .word_ready   (ser_ready),
        .bit_data_ff  (bit_data_ff),
        .bit_valid_ff (bit_valid_ff),
        .bit_ready    (bit_ready)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_sync_bits;
        @(posedge clock) disable iff (sys_rst)
        boundary |=> (word_ff[31:25] == 7'h32 && word_ff[22] && !word_ff[17]
                      && word_ff[10:9] == 2'h3);
    endproperty
    a_sync_bits: assert property (p_sync_bits)
        else $error("sync bits wrong");

    property p_pwr_rbw;
        @(posedge clock) disable iff (sys_rst)
        (boundary && reduced_bandwidth_ctl) |=> !word_ff[24] && !word_ff[20];
    endproperty
    a_pwr_rbw: assert property (p_pwr_rbw)
        else $error("flags not forced low in reduced bandwidth");

    property p_pwr_alldig;
        @(posedge clock) disable iff (sys_rst)
        (boundary && service_mode_code == 5'h02) |=> !word_ff[24];
    endproperty
    a_pwr_alldig: assert property (p_pwr_alldig)
        else $error("power flag set in all-digital");

    property p_pwr_follow;
        @(posedge clock) disable iff (sys_rst)
        (boundary && !reduced_bandwidth_ctl && service_mode_code != 5'h02)
        |=> word_ff[24] == $past(power_level_control);
    endproperty
    a_pwr_follow: assert property (p_pwr_follow)
        else $error("power flag does not follow control");

    property p_parity;
        @(posedge clock) disable iff (sys_rst)
        push_ff |-> !(^word_ff[24:23]) && !(^word_ff[21:18])
                    && !(^word_ff[16:11]) && !(^word_ff[8:0]) ^ 1'b0;
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity not even");

    property p_blk_first;
        @(posedge clock) disable iff (sys_rst)
        (boundary && state_ff == SCWA_IDLE) |=> block_counter_ff == 3'h0;
    endproperty
    a_blk_first: assert property (p_blk_first)
        else $error("first block count not zero");

    property p_blk_step;
        @(posedge clock) disable iff (sys_rst)
        (boundary && state_ff == SCWA_RUN)
        |=> block_counter_ff == $past(block_counter_ff) + 3'h1;
    endproperty
    a_blk_step: assert property (p_blk_step)
        else $error("block count did not step");

    property p_fields;
        @(posedge clock) disable iff (sys_rst)
        boundary |=> word_ff[5:1] == $past(service_mode_code)
                     && word_ff[19] == $past(audio_bandwidth_ctl)
                     && word_ff[16] == $past(reduced_bandwidth_ctl)
                     && word_ff[21] == 1'b0 && word_ff[15] == 1'b0
                     && word_ff[8:6] == 3'h0;
    endproperty
    a_fields: assert property (p_fields)
        else $error("field placement wrong");

    property p_msb_first;
        @(posedge clock) disable iff (sys_rst)
        (fifo_out_valid && ser_ready) |=> bit_valid_ff
            && bit_data_ff == $past(fifo_out_data[31]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first bit out is not bit 31");

    property p_hpid_follow;
        @(posedge clock) disable iff (sys_rst)
        (boundary && !reduced_bandwidth_ctl)
        |=> word_ff[20] == $past(high_power_control);
    endproperty
    a_hpid_follow: assert property (p_hpid_follow)
        else $error("ids flag does not follow control");

    property p_blk_hold;
        @(posedge clock) disable iff (sys_rst)
        !boundary |=> $stable(block_counter_ff);
    endproperty
    a_blk_hold: assert property (p_blk_hold)
        else $error("block count moved between boundaries");

    property p_word_push;
        @(posedge clock) disable iff (sys_rst)
        boundary |=> push_ff && block_strobe_ff;
    endproperty
    a_word_push: assert property (p_word_push)
        else $error("word not queued at boundary");

    // Empty path: bit 31 shows three edges after the boundary; the check looks four edges after
    property p_first_bit;
        @(posedge clock) disable iff (sys_rst)
        (boundary && !fifo_out_valid && !bit_valid_ff) |-> ##4 bit_valid_ff;
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("first bit late on an idle path");

    c_start: cover property (@(posedge clock)
        boundary && state_ff == SCWA_IDLE);
    c_alldig: cover property (@(posedge clock)
        boundary && service_mode_code == scwa_pkg::SMODE_ALL_DIG);
    c_wrap: cover property (@(posedge clock)
        boundary && block_counter_ff == 3'h7);
    c_rbw: cover property (@(posedge clock)
        boundary && reduced_bandwidth_ctl);
    c_drop: cover property (@(posedge clock) word_dropped_ff);
endmodule : scwa_assembler
`default_nettype wire

/* tb/scwa_mapper_model.sv */
// Behavioural subcarrier mapper: takes the serial bits and rebuilds words.
// Assumes the assembler's valid/ready bit handshake on one clock.
`timescale 1ns/1ps
`default_nettype none
module scwa_mapper_model (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        bit_data,
    input  wire logic        bit_valid,
    output logic             bit_ready,
    input  wire logic        stall,
    input  wire logic        slow,
    output logic [31:0]      rx_word_ff,
    output logic             rx_done_ff
);
    logic [4:0]  cnt_ff;
    logic [31:0] sh_ff;
    logic        tog_ff;

    // Slow mode accepts on every other cycle only
    assign bit_ready = ~stall & (~slow | tog_ff);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tog_ff <= 1'b0;
        end else begin
            tog_ff <= ~tog_ff;
        end
    end

    // First bit taken lands at the top of the word
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff     <= 5'h00;
            sh_ff      <= 32'h0;
            rx_word_ff <= 32'h0;
            rx_done_ff <= 1'b0;
        end else begin
            rx_done_ff <= 1'b0;
            if (bit_valid && bit_ready) begin
                sh_ff  <= {sh_ff[30:0], bit_data};
                cnt_ff <= cnt_ff + 5'h01;
                if (cnt_ff == 5'h1f) begin
                    rx_word_ff <= {sh_ff[30:0], bit_data};
                    rx_done_ff <= 1'b1;
                end
            end
        end
    end
endmodule : scwa_mapper_model
`default_nettype wire

/* tb/scwa_assembler_bench.sv */
// Self-checking bench for the control word assembler.
// Assumes the mapper model beside it, plus the package and rtl files.
`timescale 1ns/1ps
`default_nettype none
module scwa_assembler_bench;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        tx_enable = 1'b0;
    logic        sym_strobe = 1'b0;
    logic        plc = 1'b0, hpc = 1'b0, aud = 1'b0, rbw = 1'b0;
    logic [4:0]  smode = 5'h00;
    logic        stall = 1'b0, slow = 1'b0;
    logic        bit_data, bit_valid, bit_ready, blk_stb, dropped, rx_done;
    logic [2:0]  blk_cnt;
    logic [31:0] rx_word;
    logic [31:0] rxq[$];
    logic [31:0] expq[$];
    logic [2:0]  bc_exp = 3'h0;
    // Field masks over the received word
    localparam logic [31:0] M_SYNC = 32'hfe420600;
    localparam logic [31:0] M_PWR  = 32'h01000000;
    localparam logic [31:0] M_PAR  = 32'h00840801;
    localparam logic [31:0] M_AUD  = 32'h00080000;
    localparam logic [31:0] M_FLG  = 32'h00110000;
    localparam logic [31:0] M_BLK  = 32'h00007000;
    localparam logic [31:0] M_MODE = 32'h0000003e;
    localparam logic [31:0] M_RSV  = 32'h002081c0;
    int          err_count = 0, checks_done = 0, cycles = 0, drops = 0;
    // Control mix per block: {pl, hp, aud, rbw, mode}
    logic [8:0]  tbl [9] = '{9'h1c1, 9'h182, 9'h1e1, 9'h080, 9'h143,
                             9'h1e2, 9'h01f, 9'h1c1, 9'h101};

    always #12.5 clock = ~clock;

    scwa_assembler u_scwa_assembler (
        .clock(clock), .sys_rst(sys_rst), .tx_enable(tx_enable),
        .sym_strobe(sym_strobe), .power_level_control(plc),
        .high_power_control(hpc), .audio_bandwidth_ctl(aud),
        .reduced_bandwidth_ctl(rbw), .service_mode_code(smode),
        .bit_data_ff(bit_data), .bit_valid_ff(bit_valid),
        .bit_ready(bit_ready), .block_counter_ff(blk_cnt),
        .block_strobe_ff(blk_stb), .word_dropped_ff(dropped));

    scwa_mapper_model u_scwa_mapper_model (
        .clock(clock), .sys_rst(sys_rst), .bit_data(bit_data),
        .bit_valid(bit_valid), .bit_ready(bit_ready), .stall(stall),
        .slow(slow), .rx_word_ff(rx_word), .rx_done_ff(rx_done));

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Word as the mapper must see it, built from the field layout
    function automatic logic [31:0] exp_word(input logic [8:0] c,
                                             input logic [2:0] bc);
        logic pwr, hid;
        pwr = c[8] & ~c[5] & (c[4:0] != 5'h02);
        hid = c[7] & ~c[5];
        return {7'h32, pwr, pwr, 1'b1, 1'b0, hid, c[6], hid ^ c[6], 1'b0,
                c[5], 1'b0, bc, c[5] ^ (^bc), 2'h3, 3'h0, c[4:0],
                ^c[4:0]};
    endfunction : exp_word

    always @(posedge clock) begin
        cycles++;
        if (rx_done === 1'b1) rxq.push_back(rx_word);
        if (dropped === 1'b1) drops++;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // One block: boundary strobe, then 31 more; controls flip mid-block
    task automatic run_block(input logic [8:0] c, input bit keep);
        @(posedge clock);
        {plc, hpc, aud, rbw, smode} <= c;
        sym_strobe <= 1'b1;
        @(posedge clock);
        sym_strobe <= 1'b0;
        // Strobe stands only until the next edge; count holds until the next boundary
        #1;
        check("block strobe", {31'h0, blk_stb}, 32'h1);
        check("block count", {29'h0, blk_cnt}, {29'h0, bc_exp});
        if (keep) expq.push_back(exp_word(c, bc_exp));
        bc_exp = bc_exp + 3'h1;
        repeat (31) begin
            @(posedge clock);
            {plc, hpc, aud, rbw, smode} <= ~c;
            sym_strobe <= 1'b1;
            @(posedge clock);
            sym_strobe <= 1'b0;
        end
    endtask : run_block

    task automatic drain(input int n);
        logic [31:0] got;
        logic [31:0] want;
        while (rxq.size() < n) @(posedge clock);
        check("word count", rxq.size(), n);
        foreach (expq[i]) begin
            got  = rxq[i];
            want = expq[i];
            check("word", got, want);
            check("sync", got & M_SYNC, want & M_SYNC);
            check("power flag", got & M_PWR, want & M_PWR);
            check("pwr rule", got & M_PWR, want & M_PWR);
            check("parity", got & M_PAR, want & M_PAR);
            check("audio", got & M_AUD, want & M_AUD);
            check("flags", got & M_FLG, want & M_FLG);
            check("block", got & M_BLK, want & M_BLK);
            check("mode", got & M_MODE, want & M_MODE);
            check("reserved", got & M_RSV, want & M_RSV);
        end
        rxq.delete();
        expq.delete();
    endtask : drain

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        check("reset count", {29'h0, blk_cnt}, 32'h0);
        check("reset valid", {31'h0, bit_valid}, 32'h0);
        check("reset strobe", {31'h0, blk_stb}, 32'h0);
        check("reset drop", {31'h0, dropped}, 32'h0);
        @(posedge clock);
        tx_enable <= 1'b1;
        slow <= 1'b1;
        foreach (tbl[i]) run_block(tbl[i], 1'b1);
        drain(9);
        // Restart from idle, mapper stalled until the buffer overflows
        tx_enable <= 1'b0;
        slow <= 1'b0;
        stall <= 1'b1;
        repeat (4) @(posedge clock);
        tx_enable <= 1'b1;
        bc_exp = 3'h0;
        for (int i = 0; i < 20; i++) begin
            run_block(tbl[i % 9], i < 17);
        end
        check("dropped words", drops, 3);
        stall <= 1'b0;
        drain(17);
        stop_test();
    end
endmodule : scwa_assembler_bench
`default_nettype wire
